// ==== rtl/ppfm_pkg.sv ====
// Constants for the port pin function multiplexer.
// Assumes one 20 MHz clock and a byte-wide register port.
package ppfm_pkg;
  // ******************************************************************
  // Register offsets
  // ******************************************************************
  localparam logic [7:0] PPFM_P1_IN_OFF   = 8'h20;
  localparam logic [7:0] PPFM_P1_OUT_OFF  = 8'h21;
  localparam logic [7:0] PPFM_P1_DIR_OFF  = 8'h22;
  localparam logic [7:0] PPFM_P1_IFG_OFF  = 8'h23;
  localparam logic [7:0] PPFM_P1_IES_OFF  = 8'h24;
  localparam logic [7:0] PPFM_P1_IEN_OFF  = 8'h25;
  localparam logic [7:0] PPFM_P1_SEL_OFF  = 8'h26;
  localparam logic [7:0] PPFM_P2_IN_OFF   = 8'h28;
  localparam logic [7:0] PPFM_P2_OUT_OFF  = 8'h29;
  localparam logic [7:0] PPFM_P2_DIR_OFF  = 8'h2A;
  localparam logic [7:0] PPFM_P2_IFG_OFF  = 8'h2B;
  localparam logic [7:0] PPFM_P2_IES_OFF  = 8'h2C;
  localparam logic [7:0] PPFM_P2_IEN_OFF  = 8'h2D;
  localparam logic [7:0] PPFM_P2_SEL_OFF  = 8'h2E;
  localparam logic [7:0] PPFM_LCD_CNT_OFF = 8'h30;
  localparam logic [7:0] PPFM_IRQ_STS_OFF = 8'h31;
  localparam logic [7:0] PPFM_IRQ_CLR_OFF = 8'h32;
  localparam logic [7:0] PPFM_IRQ_EN_OFF  = 8'h33;

  // ******************************************************************
  // Field values and reset values
  // ******************************************************************
  localparam logic [7:0] PPFM_RST_BYTE    = 8'h00;
  localparam logic [2:0] PPFM_LCD_THR_P1L = 3'h5;
  localparam logic [2:0] PPFM_LCD_THR_HI  = 3'h4;
  localparam logic [2:0] PPFM_LCD_RST     = 3'h0;
  localparam int         PPFM_IRQ_P1      = 0;
  localparam int         PPFM_IRQ_P2      = 1;
endpackage

// ==== rtl/ppfm_sync3.sv ====
// Three flip-flop synchroniser for an eight pin input bus.
// Assumes asynchronous pins; a change counts when stages two and three agree.
module ppfm_sync3
  import ppfm_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] async_i,
  output logic      [7:0] level_o
);
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  logic [7:0] s3_reg;

  // ******************************************************************
  // Synchroniser chain and agreement filter
  // ******************************************************************
  // Stage one feeds only stage two to keep metastability contained
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg  <= PPFM_RST_BYTE;
      s2_reg  <= PPFM_RST_BYTE;
      s3_reg  <= PPFM_RST_BYTE;
      level_o <= PPFM_RST_BYTE;
    end else begin
      s1_reg  <= async_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      for (int i = 0; i < 8; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_o[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// ==== rtl/ppfm_top.sv ====
// Pin function multiplexer for port 1 (eight pins) and port 2 pins 0, 1.
// Assumes a byte register port, timer, clock, supervisor and serial
// peripherals on the same clock, and outside pad cells per pin.
// Summary of operation
// - P1.0 module mode: timer out 0 drives, input feeds capture 0A, dir bit rules.
// - P1.1 module mode: master clock output, input feeds capture 0B.
// - P1.3 module mode: supervisor output drives, module input unused.
// - P1.4 module mode: module output is constant low, no input use.
// - P1.5 module mode: auxiliary clock out, input feeds external timer clock.
// - P1.6 module mode: serial block sets direction, carries slave-in/master-out.
// - P1.7 module mode: serial block sets direction, carries slave-out/master-in.
// - P1.2..P1.5 are port pins below count 05h, segments 31..28 otherwise.
// - P1.6, P1.7 are port pins below count 04h, segments 27, 26 otherwise.
// - P2.1 module mode: serial clock with serial direction; segment 24 from 04h.
// - Every pin has its own interrupt enable, flag and edge select bits.
//
// Strobed register access is this design's own decision.
module ppfm_top
  import ppfm_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            irq_o,
  // Port 1 pads
  input  wire logic [7:0] p1_pin_i,
  output logic      [7:0] p1_pin_o,
  output logic      [7:0] p1_pin_oe_o,
  output logic      [7:0] p1_lcd_seg_o,
  // Port 2 pins 0 and 1 pads
  input  wire logic [1:0] p2_pin_i,
  output logic      [1:0] p2_pin_o,
  output logic      [1:0] p2_pin_oe_o,
  output logic      [1:0] p2_lcd_seg_o,
  // Peripheral outputs toward the pins
  input  wire logic       timer_out0_i,
  input  wire logic       timer_out1_i,
  input  wire logic       timer_out2_i,
  input  wire logic       master_clk_i,
  input  wire logic       aux_clk_i,
  input  wire logic       supervisor_output_i,
  input  wire logic       slave_in_master_out_line_i,
  input  wire logic       slave_out_master_in_line_i,
  input  wire logic       serial_clock_line_i,
  input  wire logic       serial_dout_dir_ctrl_i,
  input  wire logic       serial_din_dir_ctrl_i,
  input  wire logic       serial_clock_dir_ctrl_i,
  // Peripheral inputs from the pins
  output logic            capture_input_0a_o,
  output logic            capture_input_0b_o,
  output logic            capture_input_1a_o,
  output logic            capture_input_2a_o,
  output logic            external_timer_clock_o,
  output logic            slave_in_master_out_line_o,
  output logic            slave_out_master_in_line_o,
  output logic            serial_clock_line_o
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic [7:0] port1_output_value_reg;
  logic [7:0] port1_direction_reg;
  logic [7:0] port1_irq_flag_reg;
  logic [7:0] port1_irq_edge_select_reg;
  logic [7:0] port1_irq_enable_reg;
  logic [7:0] port1_function_select_reg;
  logic [7:0] port2_output_value_reg;
  logic [7:0] port2_direction_reg;
  logic [7:0] port2_irq_flag_reg;
  logic [7:0] port2_irq_edge_select_reg;
  logic [7:0] port2_irq_enable_reg;
  logic [7:0] port2_function_select_reg;
  logic [2:0] lcd_pin_count_field_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic [7:0] p1_lvl;
  logic [7:0] p2_lvl;
  logic [7:0] p1_lvl_d_reg;
  logic [7:0] p2_lvl_d_reg;
  logic [7:0] p1_edge;
  logic [7:0] p2_edge;
  logic [7:0] p1_mod_out;
  logic [7:0] p1_mod_dir;
  logic [1:0] p2_mod_out;
  logic [1:0] p2_mod_dir;
  logic [7:0] p1_out_next;
  logic [7:0] p1_oe_next;
  logic [1:0] p2_out_next;
  logic [1:0] p2_oe_next;
  logic [7:0] p2_pad_vec;
  logic [7:0] rdata_next;
  logic       lcd_low_grp;
  logic       lcd_hi_grp;

  // Byte write decode, used for every writable register
  function automatic logic wr_hit(input logic [7:0] off);
    return wr_i && (addr_i == off);
  endfunction

  // Selected edge per bit: edge select clear is rising, set is falling
  function automatic logic [7:0] sel_edge(input logic [7:0] now,
                                           input logic [7:0] prev,
                                           input logic [7:0] ies);
    return (now & ~prev & ~ies) | (~now & prev & ies);
  endfunction

  // ******************************************************************
  // Pin input synchronisers
  // ******************************************************************
  assign p2_pad_vec = {6'h00, p2_pin_i};

  ppfm_sync3 u_sync_p1 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (p1_pin_i),
    .level_o   (p1_lvl)
  );

  ppfm_sync3 u_sync_p2 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (p2_pad_vec),
    .level_o   (p2_lvl)
  );

  // ******************************************************************
  // LCD segment takeover
  // ******************************************************************
  assign lcd_low_grp = (lcd_pin_count_field_reg >= PPFM_LCD_THR_P1L);
  assign lcd_hi_grp  = (lcd_pin_count_field_reg >= PPFM_LCD_THR_HI);

  // Segment claim flags; the LCD driver owns these pads when set
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p1_lcd_seg_o <= PPFM_RST_BYTE;
      p2_lcd_seg_o <= 2'h0;
    end else begin
      p1_lcd_seg_o <= {{2{lcd_hi_grp}}, {4{lcd_low_grp}}, 2'h0};
      p2_lcd_seg_o <= {2{lcd_hi_grp}};
    end
  end

  // ******************************************************************
  // Module function routing
  // ******************************************************************
  // Peripheral signals and direction sources per pin in module mode
  always_comb begin
    p1_mod_out    = {slave_out_master_in_line_i,
                     slave_in_master_out_line_i,
                     aux_clk_i,
                     1'b0,
                     supervisor_output_i,
                     timer_out1_i,
                     master_clk_i,
                     timer_out0_i};
    p1_mod_dir    = port1_direction_reg;
    p1_mod_dir[6] = serial_dout_dir_ctrl_i;
    p1_mod_dir[7] = serial_din_dir_ctrl_i;
    p2_mod_out    = {serial_clock_line_i, timer_out2_i};
    p2_mod_dir    = {serial_clock_dir_ctrl_i, port2_direction_reg[0]};
  end

  // Pad output and enable: select picks module or port register
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port1_function_select_reg[i]) begin
        p1_out_next[i] = p1_mod_out[i];
        p1_oe_next[i]  = p1_mod_dir[i];
      end else begin
        p1_out_next[i] = port1_output_value_reg[i];
        p1_oe_next[i]  = port1_direction_reg[i];
      end
    end
    for (int j = 0; j < 2; j++) begin
      if (port2_function_select_reg[j]) begin
        p2_out_next[j] = p2_mod_out[j];
        p2_oe_next[j]  = p2_mod_dir[j];
      end else begin
        p2_out_next[j] = port2_output_value_reg[j];
        p2_oe_next[j]  = port2_direction_reg[j];
      end
    end
    // LCD pins are never driven as digital outputs
    p1_oe_next = p1_oe_next & ~{{2{lcd_hi_grp}}, {4{lcd_low_grp}}, 2'h0};
    p2_oe_next = p2_oe_next & ~{2{lcd_hi_grp}};
  end

  // Registered pad drive; one cycle of latency keeps outputs glitch free
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p1_pin_o    <= PPFM_RST_BYTE;
      p1_pin_oe_o <= PPFM_RST_BYTE;
      p2_pin_o    <= 2'h0;
      p2_pin_oe_o <= 2'h0;
    end else begin
      p1_pin_o    <= p1_out_next;
      p1_pin_oe_o <= p1_oe_next;
      p2_pin_o    <= p2_out_next;
      p2_pin_oe_o <= p2_oe_next;
    end
  end

  // Pin levels to peripheral inputs, always fed regardless of select
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      capture_input_0a_o         <= 1'b0;
      capture_input_0b_o         <= 1'b0;
      capture_input_1a_o         <= 1'b0;
      external_timer_clock_o     <= 1'b0;
      slave_in_master_out_line_o <= 1'b0;
      slave_out_master_in_line_o <= 1'b0;
      capture_input_2a_o         <= 1'b0;
      serial_clock_line_o        <= 1'b0;
    end else begin
      capture_input_0a_o         <= p1_lvl[0];
      capture_input_0b_o         <= p1_lvl[1];
      capture_input_1a_o         <= p1_lvl[2];
      external_timer_clock_o     <= p1_lvl[5];
      slave_in_master_out_line_o <= p1_lvl[6];
      slave_out_master_in_line_o <= p1_lvl[7];
      capture_input_2a_o         <= p2_lvl[0];
      serial_clock_line_o        <= p2_lvl[1];
    end
  end

  // ******************************************************************
  // Pin edge detection
  // ******************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p1_lvl_d_reg <= PPFM_RST_BYTE;
      p2_lvl_d_reg <= PPFM_RST_BYTE;
    end else begin
      p1_lvl_d_reg <= p1_lvl;
      p2_lvl_d_reg <= p2_lvl;
    end
  end

  // Edges on filtered levels only; pins 2..7 of port 2 have no pad
  assign p1_edge = sel_edge(p1_lvl, p1_lvl_d_reg, port1_irq_edge_select_reg);
  assign p2_edge = sel_edge(p2_lvl, p2_lvl_d_reg, port2_irq_edge_select_reg);

  // ******************************************************************
  // Port configuration registers
  // ******************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port1_output_value_reg    <= PPFM_RST_BYTE;
      port1_direction_reg       <= PPFM_RST_BYTE;
      port1_irq_edge_select_reg <= PPFM_RST_BYTE;
      port1_irq_enable_reg      <= PPFM_RST_BYTE;
      port1_function_select_reg <= PPFM_RST_BYTE;
    end else begin
      if (wr_hit(PPFM_P1_OUT_OFF)) port1_output_value_reg    <= wdata_i;
      if (wr_hit(PPFM_P1_DIR_OFF)) port1_direction_reg       <= wdata_i;
      if (wr_hit(PPFM_P1_IES_OFF)) port1_irq_edge_select_reg <= wdata_i;
      if (wr_hit(PPFM_P1_IEN_OFF)) port1_irq_enable_reg      <= wdata_i;
      if (wr_hit(PPFM_P1_SEL_OFF)) port1_function_select_reg <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port2_output_value_reg    <= PPFM_RST_BYTE;
      port2_direction_reg       <= PPFM_RST_BYTE;
      port2_irq_edge_select_reg <= PPFM_RST_BYTE;
      port2_irq_enable_reg      <= PPFM_RST_BYTE;
      port2_function_select_reg <= PPFM_RST_BYTE;
      lcd_pin_count_field_reg   <= PPFM_LCD_RST;
    end else begin
      if (wr_hit(PPFM_P2_OUT_OFF)) port2_output_value_reg    <= wdata_i;
      if (wr_hit(PPFM_P2_DIR_OFF)) port2_direction_reg       <= wdata_i;
      if (wr_hit(PPFM_P2_IES_OFF)) port2_irq_edge_select_reg <= wdata_i;
      if (wr_hit(PPFM_P2_IEN_OFF)) port2_irq_enable_reg      <= wdata_i;
      if (wr_hit(PPFM_P2_SEL_OFF)) port2_function_select_reg <= wdata_i;
      if (wr_hit(PPFM_LCD_CNT_OFF)) lcd_pin_count_field_reg  <= wdata_i[2:0];
    end
  end

  // ******************************************************************
  // Interrupt flags
  // ******************************************************************
  // Flags are writable by software; a pin edge in the same cycle wins
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port1_irq_flag_reg <= PPFM_RST_BYTE;
      port2_irq_flag_reg <= PPFM_RST_BYTE;
    end else begin
      if (wr_hit(PPFM_P1_IFG_OFF)) begin
        port1_irq_flag_reg <= wdata_i | p1_edge;
      end else begin
        port1_irq_flag_reg <= port1_irq_flag_reg | p1_edge;
      end
      if (wr_hit(PPFM_P2_IFG_OFF)) begin
        port2_irq_flag_reg <= wdata_i | p2_edge;
      end else begin
        port2_irq_flag_reg <= port2_irq_flag_reg | p2_edge;
      end
    end
  end

  // Sticky summary status per port; set wins over the clear register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_reg <= 2'h0;
      irq_enable_reg <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if ((k == PPFM_IRQ_P1) ? |(p1_edge & port1_irq_enable_reg)
                               : |(p2_edge & port2_irq_enable_reg)) begin
          irq_status_reg[k] <= 1'b1;
        end else if (wr_hit(PPFM_IRQ_CLR_OFF) && wdata_i[k]) begin
          irq_status_reg[k] <= 1'b0;
        end
      end
      if (wr_hit(PPFM_IRQ_EN_OFF)) irq_enable_reg <= wdata_i[1:0];
    end
  end

  assign irq_o = |(irq_status_reg & irq_enable_reg);

  // ******************************************************************
  // Read path
  // ******************************************************************
  always_comb begin
    unique case (addr_i)
      PPFM_P1_IN_OFF:   rdata_next = p1_lvl;
      PPFM_P1_OUT_OFF:  rdata_next = port1_output_value_reg;
      PPFM_P1_DIR_OFF:  rdata_next = port1_direction_reg;
      PPFM_P1_IFG_OFF:  rdata_next = port1_irq_flag_reg;
      PPFM_P1_IES_OFF:  rdata_next = port1_irq_edge_select_reg;
      PPFM_P1_IEN_OFF:  rdata_next = port1_irq_enable_reg;
      PPFM_P1_SEL_OFF:  rdata_next = port1_function_select_reg;
      PPFM_P2_IN_OFF:   rdata_next = p2_lvl;
      PPFM_P2_OUT_OFF:  rdata_next = port2_output_value_reg;
      PPFM_P2_DIR_OFF:  rdata_next = port2_direction_reg;
      PPFM_P2_IFG_OFF:  rdata_next = port2_irq_flag_reg;
      PPFM_P2_IES_OFF:  rdata_next = port2_irq_edge_select_reg;
      PPFM_P2_IEN_OFF:  rdata_next = port2_irq_enable_reg;
      PPFM_P2_SEL_OFF:  rdata_next = port2_function_select_reg;
      PPFM_LCD_CNT_OFF: rdata_next = {5'h00, lcd_pin_count_field_reg};
      PPFM_IRQ_STS_OFF: rdata_next = {6'h00, irq_status_reg};
      PPFM_IRQ_EN_OFF:  rdata_next = {6'h00, irq_enable_reg};
      default:          rdata_next = PPFM_RST_BYTE; // Unmapped and clear reg
    endcase
  end

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= PPFM_RST_BYTE;
    end else begin
      rdata_o <= rd_i ? rdata_next : PPFM_RST_BYTE;
    end
  end
endmodule

// ==== test/ppfm_pad_model.sv ====
// Pad model for a group of pins with an outside driver.
// Assumes the bench chooses which pins the outside world drives.
module ppfm_pad_model #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic [W-1:0] pin_o_i,
  input  wire logic [W-1:0] pin_oe_i,
  input  wire logic [W-1:0] ext_en_i,
  input  wire logic [W-1:0] ext_val_i,
  output logic      [W-1:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // Pad resolution
  // ******
  logic tog_reg = 1'b0;

  // Floating pads wander each cycle; a held level would hide a missing drive
  always @(posedge ref_clk_i) begin
    tog_reg <= ~tog_reg;
  end

  // Block drive wins, then the outside driver
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pad_o[i] = pin_oe_i[i] ? pin_o_i[i] : (ext_en_i[i] ? ext_val_i[i] : tog_reg);
    end
  end
endmodule

// ==== test/ppfm_top_sva.sv ====
// Port checker for the pin function multiplexer.
// Assumes registers change only through the byte register port.
module ppfm_top_sva
  import ppfm_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o,
  input wire logic [7:0] p1_pin_o,
  input wire logic [7:0] p1_pin_oe_o,
  input wire logic [7:0] p1_lcd_seg_o,
  input wire logic [1:0] p2_lcd_seg_o,
  input wire logic       timer_out0_i,
  input wire logic       slave_in_master_out_line_i,
  input wire logic       serial_dout_dir_ctrl_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // Shadow registers
  // ******
  logic [7:0] sel1_reg;
  logic [7:0] dir1_reg;
  logic [1:0] ien_reg;
  logic [2:0] lcd_reg;

  // Mirrors of control writes, from the port alone
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel1_reg <= 8'h00;
      dir1_reg <= 8'h00;
      ien_reg  <= 2'h0;
      lcd_reg  <= 3'h0;
    end else if (wr_i) begin
      if (addr_i == PPFM_P1_SEL_OFF) sel1_reg <= wdata_i;
      if (addr_i == PPFM_P1_DIR_OFF) dir1_reg <= wdata_i;
      if (addr_i == PPFM_IRQ_EN_OFF) ien_reg <= wdata_i[1:0];
      if (addr_i == PPFM_LCD_CNT_OFF) lcd_reg <= wdata_i[2:0];
    end
  end

  // ******
  // Assertions
  // ******
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // A cycle that follows no read strobe
  sequence s_no_read;
    !rd_i ##1 1'b1;
  endsequence

  a_read_idle: assert property (s_no_read |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_seg_p1_low: assert property (
    p1_lcd_seg_o[5:0] == {{4{$past(lcd_reg) >= PPFM_LCD_THR_P1L}}, 2'h0})
    else $error("low segment pins wrong");
  a_seg_upper: assert property (
    {p1_lcd_seg_o[7:6], p2_lcd_seg_o} == {4{$past(lcd_reg) >= PPFM_LCD_THR_HI}})
    else $error("upper segment pins wrong");
  a_seg_oe_off: assert property (
    $past(lcd_reg) >= PPFM_LCD_THR_P1L |-> p1_pin_oe_o[5:2] == 4'h0)
    else $error("segment pin still driven");
  a_pin0_timer: assert property (
    $past(sel1_reg[0]) |-> p1_pin_o[0] == $past(timer_out0_i))
    else $error("pin 0 not following timer output");
  a_dir_low_pins: assert property (p1_pin_oe_o[1:0] == $past(dir1_reg[1:0]))
    else $error("pin 0 or 1 enable not from direction");
  a_simo_dir: assert property (
    $past(sel1_reg[6]) && $past(lcd_reg) < PPFM_LCD_THR_HI && $past(serial_dout_dir_ctrl_i)
    |-> p1_pin_oe_o[6] && p1_pin_o[6] == $past(slave_in_master_out_line_i))
    else $error("pin 6 not under serial control");
  a_irq_masked: assert property (ien_reg == 2'h0 |-> !irq_o)
    else $error("interrupt with all enables clear");
endmodule

bind ppfm_top ppfm_top_sva i_sva (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .p1_pin_o(p1_pin_o),
  .p1_pin_oe_o(p1_pin_oe_o), .p1_lcd_seg_o(p1_lcd_seg_o), .p2_lcd_seg_o(p2_lcd_seg_o),
  .timer_out0_i(timer_out0_i), .slave_in_master_out_line_i(slave_in_master_out_line_i),
  .serial_dout_dir_ctrl_i(serial_dout_dir_ctrl_i)
);

// ==== test/tb.sv ====
// Self-checking bench for the pin function multiplexer.
// Assumes pad models on both ports and a 20 MHz reference clock.
`define CHK(N, E, G) begin \
  checked++; \
  if ((G) !== (E)) begin \
    mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", N, E, G); \
  end \
end
module tb
  import ppfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // Signals and instances
  // ******
  logic        clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, irq;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, en1 = 8'hFF, v1 = 8'h00;
  logic [7:0]  rdata, pad1, o1, oe1, seg1, cap;
  logic [1:0]  en2 = 2'h3, v2 = 2'h0, pad2, o2, oe2, seg2;
  logic [11:0] per = 12'h000;
  int          mismatches = 0, checked = 0;

  ppfm_top i_dut (
    .ref_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq), .p1_pin_i(pad1), .p1_pin_o(o1), .p1_pin_oe_o(oe1),
    .p1_lcd_seg_o(seg1), .p2_pin_i(pad2), .p2_pin_o(o2), .p2_pin_oe_o(oe2),
    .p2_lcd_seg_o(seg2), .timer_out0_i(per[0]), .timer_out1_i(per[1]),
    .timer_out2_i(per[2]), .master_clk_i(per[3]), .aux_clk_i(per[4]),
    .supervisor_output_i(per[5]), .slave_in_master_out_line_i(per[6]),
    .slave_out_master_in_line_i(per[7]), .serial_clock_line_i(per[8]),
    .serial_dout_dir_ctrl_i(per[9]), .serial_din_dir_ctrl_i(per[10]),
    .serial_clock_dir_ctrl_i(per[11]), .capture_input_0a_o(cap[0]),
    .capture_input_0b_o(cap[1]), .capture_input_1a_o(cap[2]), .capture_input_2a_o(cap[3]),
    .external_timer_clock_o(cap[4]), .slave_in_master_out_line_o(cap[5]),
    .slave_out_master_in_line_o(cap[6]), .serial_clock_line_o(cap[7])
  );
  ppfm_pad_model #(.W(8)) i_pad1 (.ref_clk_i(clk), .pin_o_i(o1), .pin_oe_i(oe1),
    .ext_en_i(en1), .ext_val_i(v1), .pad_o(pad1));
  ppfm_pad_model #(.W(2)) i_pad2 (.ref_clk_i(clk), .pin_o_i(o2), .pin_oe_i(oe2),
    .ext_en_i(en2), .ext_val_i(v2), .pad_o(pad2));

  always #25 clk = ~clk;

  // ******
  // Bus and helper tasks
  // ******
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    `CHK(n, e, rdata)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pins(input logic [7:0] a, input logic [1:0] b);
    @(posedge clk);
    v1 <= a;
    v2 <= b;
    settle(8);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ******
  // Scenarios
  // ******
  // Reset values, read back, then read-only and unmapped places
  task automatic t_regs();
    logic [7:0] a [14] = '{PPFM_P1_IFG_OFF, PPFM_P2_IFG_OFF, PPFM_P1_OUT_OFF,
      PPFM_P1_DIR_OFF, PPFM_P1_IES_OFF, PPFM_P1_IEN_OFF, PPFM_P1_SEL_OFF, PPFM_P2_OUT_OFF,
      PPFM_P2_DIR_OFF, PPFM_P2_IES_OFF, PPFM_P2_IEN_OFF, PPFM_P2_SEL_OFF,
      PPFM_LCD_CNT_OFF, PPFM_IRQ_EN_OFF};
    logic [7:0] ro [5] = '{PPFM_P1_IN_OFF, PPFM_P2_IN_OFF, PPFM_IRQ_STS_OFF,
      PPFM_IRQ_CLR_OFF, 8'h27};
    logic [7:0] m;
    foreach (a[i]) begin
      m = (a[i] == PPFM_LCD_CNT_OFF) ? 8'h07 : (a[i] == PPFM_IRQ_EN_OFF) ? 8'h03 : 8'hFF;
      rchk("reset value", a[i], 8'h00);
      wr_reg(a[i], 8'hA5);
      rchk("read back", a[i], 8'hA5 & m);
      wr_reg(a[i], 8'h00);
    end
    foreach (ro[i]) begin
      wr_reg(ro[i], 8'hFF);
      rchk("read only", ro[i], 8'h00);
    end
  endtask
  // Port mode drive and pin level readback
  task automatic t_gpio();
    wr_reg(PPFM_P1_OUT_OFF, 8'hC3);
    wr_reg(PPFM_P2_OUT_OFF, 8'h02);
    wr_reg(PPFM_P1_DIR_OFF, 8'hFF);
    wr_reg(PPFM_P2_DIR_OFF, 8'h03);
    en1 <= 8'h00;
    en2 <= 2'h0;
    settle(6);
    `CHK("p1 drive", 8'hC3, o1)
    `CHK("p2 drive", 2'h2, o2)
    rchk("p1 level", PPFM_P1_IN_OFF, 8'hC3);
    @(posedge clk);
    en1 <= 8'hFF;
    en2 <= 2'h3;
    wr_reg(PPFM_P1_DIR_OFF, 8'h00);
    wr_reg(PPFM_P2_DIR_OFF, 8'h00);
    settle(2);
    `CHK("p1 enable", 8'h00, oe1)
  endtask
  // Module mode outputs for three patterns, then module inputs
  task automatic t_module();
    logic [11:0] pats [3] = '{12'hFFF, 12'h5A6, 12'h000};
    logic [11:0] p;
    logic [7:0]  e, eo;
    wr_reg(PPFM_P1_SEL_OFF, 8'hFF);
    wr_reg(PPFM_P2_SEL_OFF, 8'h03);
    wr_reg(PPFM_P1_DIR_OFF, 8'h3F);
    wr_reg(PPFM_P2_DIR_OFF, 8'h01);
    foreach (pats[k]) begin
      p = pats[k];
      @(posedge clk);
      per <= p;
      settle(2);
      e = {p[7:6], p[4], 1'h0, p[5], p[1], p[3], p[0]};
      eo = {p[10:9], 6'h3F};
      `CHK("p1 enable", eo, oe1)
      `CHK("p1 drive", e & eo, o1 & eo)
      `CHK("p2 enable", {p[11], 1'h1}, oe2)
      `CHK("p2 drive", {p[8] & p[11], p[2]}, o2 & {p[11], 1'h1})
    end
    wr_reg(PPFM_P1_DIR_OFF, 8'h00);
    wr_reg(PPFM_P2_DIR_OFF, 8'h00);
    for (int k = 0; k < 2; k++) begin
      pins(k ? 8'h5A : 8'hA5, k ? 2'h2 : 2'h1);
      `CHK("capture", k ? 8'hA2 : 8'h5D, cap)
    end
    pins(8'h00, 2'h0);
  endtask
  // Every pin count value against both thresholds
  task automatic t_lcd();
    logic [7:0] e;
    wr_reg(PPFM_P1_SEL_OFF, 8'h00);
    wr_reg(PPFM_P2_SEL_OFF, 8'h00);
    wr_reg(PPFM_P1_DIR_OFF, 8'hFF);
    wr_reg(PPFM_P2_DIR_OFF, 8'h03);
    for (int n = 0; n < 8; n++) begin
      wr_reg(PPFM_LCD_CNT_OFF, 8'(n));
      settle(2);
      e = {{2{n >= 4}}, {4{n >= 5}}, 2'h0};
      `CHK("p1 segments", e, seg1)
      `CHK("p1 enable", ~e, oe1)
      `CHK("p2 segments", {2{n >= 4}}, seg2)
      `CHK("p2 enable", {2{n < 4}}, oe2)
    end
    wr_reg(PPFM_LCD_CNT_OFF, 8'h00);
    wr_reg(PPFM_P1_DIR_OFF, 8'h00);
    wr_reg(PPFM_P2_DIR_OFF, 8'h00);
  endtask
  // Edge selects, flags, summary status, masking and clearing
  task automatic t_irq();
    pins(8'h00, 2'h0); // Drain old edges
    wr_reg(PPFM_P1_IFG_OFF, 8'h00);
    wr_reg(PPFM_P2_IFG_OFF, 8'h00);
    wr_reg(PPFM_IRQ_CLR_OFF, 8'h03);
    wr_reg(PPFM_P1_IES_OFF, 8'h80);
    wr_reg(PPFM_P1_IEN_OFF, 8'h81);
    wr_reg(PPFM_P2_IEN_OFF, 8'h02);
    wr_reg(PPFM_IRQ_EN_OFF, 8'h03);
    pins(8'h03, 2'h0);
    rchk("p1 flags", PPFM_P1_IFG_OFF, 8'h03);
    rchk("status", PPFM_IRQ_STS_OFF, 8'h01);
    `CHK("irq raised", 1'h1, irq)
    pins(8'h83, 2'h0);
    rchk("falling only", PPFM_P1_IFG_OFF, 8'h03);
    pins(8'h03, 2'h0);
    rchk("falling seen", PPFM_P1_IFG_OFF, 8'h83);
    wr_reg(PPFM_IRQ_EN_OFF, 8'h00);
    settle(1);
    `CHK("irq masked", 1'h0, irq)
    wr_reg(PPFM_IRQ_EN_OFF, 8'h03);
    wr_reg(PPFM_P1_IFG_OFF, 8'h00);
    wr_reg(PPFM_IRQ_CLR_OFF, 8'h01);
    settle(1);
    `CHK("irq cleared", 1'h0, irq)
    rchk("status clear", PPFM_IRQ_STS_OFF, 8'h00);
    pins(8'h03, 2'h2);
    rchk("p2 flags", PPFM_P2_IFG_OFF, 8'h02);
    rchk("p2 status", PPFM_IRQ_STS_OFF, 8'h02);
    `CHK("p2 irq", 1'h1, irq)
  endtask

  // ******
  // Main sequence and watchdog
  // ******
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_gpio();
    t_module();
    t_lcd();
    t_irq();
    end_sim();
  end
  // Far beyond the expected run
  initial begin
    #500000;
    mismatches++;
    end_sim();
  end
endmodule
